// ---- logic/eisr_regs.vh ----
// constants for the external interrupt sync router
`ifndef EISR_REGS_VH
`define EISR_REGS_VH
`define EISR_NUM_SRC 20
`define EISR_NUM_REQ 4
`define EISR_SIMPLE_LSB 4
`define EISR_WAKE_LSB 12
`define EISR_LAT_REQ 10
`define EISR_LAT_GPIO 12
`define EISR_FIXED_STAGES 5
`define EISR_SYNC_STAGES 2
`define EISR_GROUPS 4
`define EISR_GRP_W 2
`endif

// ---- logic/eisr_delay.v ----
// fixed-length pipeline delay for an encoded request
module eisr_delay #(
	parameter DEPTH = 4,
	parameter WIDTH = 6
) (
	mclk,
	sys_rst,
	din,
	dout
);
	input wire mclk;
	input wire sys_rst;
	input wire [WIDTH-1:0] din;
	output wire [WIDTH-1:0] dout;

	reg [WIDTH-1:0] pipe_q [0:DEPTH-1];
	integer i;

	always @(posedge mclk) begin
		if (sys_rst) begin
			for (i = 0; i < DEPTH; i = i + 1) begin
				pipe_q[i] <= {WIDTH{1'b0}};
			end
		end else begin
			pipe_q[0] <= din;
			for (i = 1; i < DEPTH; i = i + 1) begin
				pipe_q[i] <= pipe_q[i-1];
			end
		end
	end

	assign dout = pipe_q[DEPTH-1];
endmodule

// ---- logic/eisr_router.v ----
// external interrupt synchroniser, pending flags, grouper and encoder
// Summary of operation
// [RULE_01] four request pins, eight simple gpio pins, eight wakeup gpio pins are accepted
// [RULE_02] simple gpio inputs are ignored in power-down; wakeup pins still signal
// [RULE_03] unloaded source reaches core in 10 (request) or 12 (gpio) cycles
// [RULE_04] with several pending, lower priority sources wait extra cycles
// [RULE_05] every pin is synchronised before any other logic uses it
// [RULE_06] driver holds each pin asserted longer than one clock period
// [RULE_07] repeat of a still-pending source is dropped, never queued
// [RULE_08] grouping and group-to-core mapping are set by software inputs
// [RULE_09] per-source pending flag, cleared only by software; core line follows flags
`include "eisr_regs.vh"
module eisr_router (
	mclk,
	sys_rst,
	external_request_0,
	external_request_1,
	external_request_2,
	external_request_3,
	simple_gpio_irq_a,
	simple_gpio_irq_b,
	simple_gpio_irq_c,
	simple_gpio_irq_d,
	simple_gpio_irq_e,
	simple_gpio_irq_f,
	simple_gpio_irq_g,
	simple_gpio_irq_h,
	wakeup_pin_a,
	wakeup_pin_b,
	wakeup_pin_c,
	wakeup_pin_d,
	wakeup_pin_e,
	wakeup_pin_f,
	wakeup_pin_g,
	wakeup_pin_h,
	power_down,
	src_enable,
	src_group,
	group_critical,
	req0_critical,
	pend_clear,
	pending,
	core_int,
	core_cint,
	active_src
);
	input wire mclk;
	input wire sys_rst;
	input wire external_request_0;
	input wire external_request_1;
	input wire external_request_2;
	input wire external_request_3;
	input wire simple_gpio_irq_a;
	input wire simple_gpio_irq_b;
	input wire simple_gpio_irq_c;
	input wire simple_gpio_irq_d;
	input wire simple_gpio_irq_e;
	input wire simple_gpio_irq_f;
	input wire simple_gpio_irq_g;
	input wire simple_gpio_irq_h;
	input wire wakeup_pin_a;
	input wire wakeup_pin_b;
	input wire wakeup_pin_c;
	input wire wakeup_pin_d;
	input wire wakeup_pin_e;
	input wire wakeup_pin_f;
	input wire wakeup_pin_g;
	input wire wakeup_pin_h;
	input wire power_down;
	input wire [`EISR_NUM_SRC-1:0] src_enable;
	input wire [2*`EISR_NUM_SRC-1:0] src_group;
	input wire [`EISR_GROUPS-1:0] group_critical;
	input wire req0_critical;
	input wire [`EISR_NUM_SRC-1:0] pend_clear;
	output reg [`EISR_NUM_SRC-1:0] pending;
	output reg core_int;
	output reg core_cint;
	output reg [4:0] active_src;

	localparam NS = `EISR_NUM_SRC;
	// registered stages outside the delay lines: two sync flops, pending, select, output;
	// the edge detect is combinational and adds no cycle, so it is not counted
	// the delay lines make up the rest, so each class keeps its fixed latency
	localparam PAD_REQ = `EISR_LAT_REQ - `EISR_FIXED_STAGES;
	localparam PAD_GPIO = `EISR_LAT_GPIO - `EISR_FIXED_STAGES;

	wire [NS-1:0] pins;
	reg [NS-1:0] sync1_q;
	reg [NS-1:0] sync2_q;
	reg [NS-1:0] prev_q;
	reg [NS-1:0] seen;
	reg [NS-1:0] live;
	reg hit_v;
	reg [4:0] sel_idx;
	reg sel_crit;
	reg [6:0] sel_q;
	wire [6:0] req_out;
	wire [6:0] gpio_out;
	reg [6:0] sel_req_d;
	reg [6:0] sel_gpio_d;
	integer k;

	assign pins = {wakeup_pin_h, wakeup_pin_g, wakeup_pin_f, wakeup_pin_e,
		wakeup_pin_d, wakeup_pin_c, wakeup_pin_b, wakeup_pin_a,
		simple_gpio_irq_h, simple_gpio_irq_g, simple_gpio_irq_f, simple_gpio_irq_e,
		simple_gpio_irq_d, simple_gpio_irq_c, simple_gpio_irq_b, simple_gpio_irq_a,
		external_request_3, external_request_2, external_request_1,
		external_request_0}; // RULE_01

	function [1:0] grp_of;
		input [2*`EISR_NUM_SRC-1:0] map;
		input [4:0] idx;
		begin
			grp_of = map[idx*2 +: 2];
		end
	endfunction

	// two-flop synchroniser; first stage feeds only the second
	always @(posedge mclk) begin
		if (sys_rst) begin
			sync1_q <= {NS{1'b0}};
			sync2_q <= {NS{1'b0}};
			prev_q <= {NS{1'b0}};
		end else begin
			sync1_q <= pins; // RULE_05
			sync2_q <= sync1_q; // RULE_05
			prev_q <= sync2_q;
		end
	end

	// rising-edge recognition; a pulse under one clock may be missed by the sampler
	always @* begin
		seen = sync2_q & ~prev_q; // RULE_06
		if (power_down) begin
			seen[`EISR_WAKE_LSB-1:`EISR_SIMPLE_LSB] = 8'h00; // RULE_02
		end
	end

	// set wins over clear; a repeat while pending changes nothing
	always @(posedge mclk) begin
		if (sys_rst) begin
			pending <= {NS{1'b0}};
		end else begin
			pending <= (pending & ~pend_clear) | (seen & ~pending) | (seen & pend_clear); // RULE_07 RULE_09
		end
	end

	// fixed priority: lowest index wins, others wait their turn
	always @* begin
		live = pending & src_enable;
		hit_v = 1'b0;
		sel_idx = 5'h00;
		for (k = NS - 1; k >= 0; k = k - 1) begin
			if (live[k]) begin
				hit_v = 1'b1; // RULE_04
				sel_idx = k[4:0];
			end
		end
		if (sel_idx == 5'h00) begin
			sel_crit = req0_critical;
		end else begin
			sel_crit = group_critical[grp_of(src_group, sel_idx)]; // RULE_08
		end
	end

	// select register; a change of winner restarts the full latency
	always @(posedge mclk) begin
		if (sys_rst) begin
			sel_q <= 7'h00;
		end else begin
			sel_q <= {hit_v, sel_crit, sel_idx};
		end
	end

	// split by class so each class sees its own latency
	always @* begin
		sel_req_d = 7'h00;
		sel_gpio_d = 7'h00;
		if (sel_q[4:0] < `EISR_NUM_REQ) begin
			sel_req_d = sel_q;
		end else begin
			sel_gpio_d = sel_q;
		end
	end

	// separate delay lines give the two documented latencies
	eisr_delay #(.DEPTH(PAD_REQ), .WIDTH(7)) u_dly_req (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.din(sel_req_d),
		.dout(req_out)
	); // RULE_03

	eisr_delay #(.DEPTH(PAD_GPIO), .WIDTH(7)) u_dly_gpio (
		.mclk(mclk),
		.sys_rst(sys_rst),
		.din(sel_gpio_d),
		.dout(gpio_out)
	); // RULE_03

	// outputs hold while the delayed view shows a live flag still set
	// request line looked at first: it only ever carries the lowest indices
	// limitation: a new winner reaches the core line only once its latency has run; the old winner shows meanwhile if still live, else the line is low
	always @(posedge mclk) begin
		if (sys_rst) begin
			core_int <= 1'b0;
			core_cint <= 1'b0;
			active_src <= 5'h00;
		end else if (req_out[6] && live[req_out[4:0]]) begin
			core_int <= ~req_out[5]; // RULE_09
			core_cint <= req_out[5];
			active_src <= req_out[4:0];
		end else if (gpio_out[6] && live[gpio_out[4:0]]) begin
			core_int <= ~gpio_out[5];
			core_cint <= gpio_out[5];
			active_src <= gpio_out[4:0];
		end else begin
			core_int <= 1'b0;
			core_cint <= 1'b0;
			active_src <= 5'h00;
		end
	end
endmodule

// ---- testbench/eisr_router_asserts.sv ----
// concurrent checks on the router ports
module eisr_chk (
	input wire logic mclk,
	input wire logic sys_rst,
	input wire logic external_request_0,
	input wire logic simple_gpio_irq_a,
	input wire logic power_down,
	input wire logic req0_critical,
	input wire logic [19:0] src_enable,
	input wire logic [19:0] pend_clear,
	input wire logic [19:0] pending,
	input wire logic core_int,
	input wire logic core_cint,
	input wire logic [4:0] active_src,
	input wire logic [3:0] group_critical,
	input wire logic [39:0] src_group
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge mclk);
	endclocking
	default disable iff (sys_rst);
	sequence s_idle;
		((pending & src_enable) == 20'h0) [*6];
	endsequence
	a_req_lat: assert property ($rose(external_request_0) && src_enable[0] && req0_critical && !pending
		&& !core_cint |-> !core_cint [*8] ##1 !core_cint [*2] ##1 core_cint) else $error("req latency");
	a_gpio_lat: assert property ($rose(simple_gpio_irq_a) && src_enable[4] && !power_down && !pending
		&& !core_int && !group_critical[src_group[9:8]] |-> !core_int [*8] ##1 !core_int [*4] ##1 core_int)
		else $error("gpio latency");
	a_sync_first: assert property ($rose(external_request_0) && !pending[0] |=> !pending[0] ##1 !pending[0]
		##1 pending[0]) else $error("sync");
	a_pd_mask: assert property ($rose(pending[4]) |-> !($past(power_down) && $past(power_down, 2)
		&& $past(power_down, 3))) else $error("power down leak");
	a_pend_stick: assert property (($past(pending) & ~pending & ~$past(pend_clear)) == 20'h0) else $error("lost");
	a_core_idle: assert property (s_idle ##1 s_idle |-> !core_int && !core_cint) else $error("core stuck");
	a_prio_low: assert property ((pending[0] && src_enable[0]) [*8] ##1 (pending[0] && src_enable[0]) [*4]
		|-> active_src == 5'h0) else $error("priority");
	a_no_queue: assert property (!external_request_0 [*5] ##0 pend_clear[0] |=> !pending[0] [*2])
		else $error("queued");
endmodule
bind eisr_router eisr_chk i_eisr_chk (.*);

// ---- testbench/eisr_pins.sv ----
// pin driver model: each request becomes a two-cycle pulse
module eisr_pins (
	input wire logic mclk,
	input wire logic [19:0] fire,
	output logic [19:0] pins = 0
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [19:0] p1 = 0;
	always @(posedge mclk) begin
		p1 <= fire;
		pins <= fire | p1;
	end
endmodule

// ---- testbench/eisr_router_tb_top.sv ----
// self-checking bench for the interrupt router
module eisr_router_tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic mclk = 0, sys_rst = 1, power_down = 0, req0_critical = 0, core_int, core_cint;
	logic [19:0] src_enable = 20'hfffff, pend_clear = 0, fire = 0, pins, pending;
	logic [39:0] src_group = 0;
	logic [3:0] group_critical = 0;
	logic [4:0] active_src;
	int n_mismatch = 0, n_checks = 0;
	// row: source, power-down, req0 critical, expected normal and critical lines
	logic [8:0] rows [8] = '{9'h005, 9'h002, 9'h032, 9'h042, 9'h048, 9'h0b8, 9'h0ca, 9'h132};
	eisr_pins i_eisr_pins (.*);
	eisr_router i_eisr_router (.*, .external_request_0(pins[0]), .external_request_1(pins[1]),
		.external_request_2(pins[2]), .external_request_3(pins[3]), .simple_gpio_irq_a(pins[4]),
		.simple_gpio_irq_b(pins[5]), .simple_gpio_irq_c(pins[6]), .simple_gpio_irq_d(pins[7]),
		.simple_gpio_irq_e(pins[8]), .simple_gpio_irq_f(pins[9]), .simple_gpio_irq_g(pins[10]),
		.simple_gpio_irq_h(pins[11]), .wakeup_pin_a(pins[12]), .wakeup_pin_b(pins[13]), .wakeup_pin_c(pins[14]),
		.wakeup_pin_d(pins[15]), .wakeup_pin_e(pins[16]), .wakeup_pin_f(pins[17]), .wakeup_pin_g(pins[18]),
		.wakeup_pin_h(pins[19]));
	always #2.5 mclk = ~mclk;
	task chk(string n, logic [19:0] g, logic [19:0] e);
		n_checks++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask
	task automatic pulse(ref logic [19:0] s, input logic [19:0] v, input int w);
		s = v;
		@(posedge mclk);
		#1 s = 0;
		repeat (w) @(posedge mclk);
		#1;
	endtask
	task wrap_up;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	initial begin
		repeat (20) @(posedge mclk);
		#1 sys_rst = 0;
		foreach (rows[i]) begin
			{power_down, req0_critical} = rows[i][3:2];
			pulse(fire, 20'h1 << rows[i][8:4], 16);
			chk("pending", pending, |rows[i][1:0] ? 20'h1 << rows[i][8:4] : 20'h0);
			chk("core", {core_int, core_cint}, rows[i][1:0]);
			pulse(pend_clear, '1, 12);
		end
		// two sources at once: the lower index is served first
		pulse(fire, 20'h24, 16);
		chk("active", active_src, 2);
		pulse(pend_clear, 4, 20);
		chk("active", active_src, 5);
		pulse(pend_clear, '1, 12);
		// gpio source moved to a group that maps onto the critical line
		src_group = 40'h200;
		group_critical = 4'h4;
		pulse(fire, 20'h10, 16);
		chk("group", {core_int, core_cint}, 1);
		pulse(pend_clear, '1, 12);
		{src_group, group_critical} = 0;
		// a disabled source keeps its flag but never reaches the core
		src_enable = 20'hffff7;
		pulse(fire, 20'h8, 16);
		chk("disabled", {pending[3], core_int, core_cint}, 4);
		pulse(pend_clear, '1, 12);
		src_enable = 20'hfffff;
		pulse(fire, 1, 16);
		pulse(fire, 1, 16);
		pulse(pend_clear, 1, 16);
		chk("repeat", {pending[0], core_int}, 0);
		pulse(fire, 1, 16);
		sys_rst = 1;
		@(posedge mclk);
		#1 chk("reset", pending, 0);
		chk("reset out", {core_int, core_cint, active_src}, 0);
		wrap_up;
	end
endmodule
